/* common/sar_adc_defines.vh */
/*
 * Constants of the 12-bit successive-approximation conversion control block:
 * register indices, field positions, reset values and timing divides.
 * Assumes APB byte address = 4 * register index, data in the low byte lanes.
 */
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

// ***********************************************
// Register indices (byte address is index * 4)
// ***********************************************
`define IDX_SCAN_CONTROL 14'h0097
`define IDX_RESULT_LOW 14'h0099
`define IDX_RESULT_HIGH 14'h009A
`define IDX_POWER_CONTROL 14'h2024
`define IDX_SAMPLE_TIME 14'h2053
`define IDX_CLOCK_CONTROL 14'h20A0
`define IDX_PIN_SELECT 14'h20A1
`define IDX_IRQ_STATUS 14'h20A2
`define IDX_IRQ_MASK 14'h20A3

// ***********************************************
// Fields
// ***********************************************
`define SCAN_START_BIT 0
`define SCAN_CHAN_LSB 1
`define SCAN_CHAN_MSB 5
`define SCAN_TRIG_BIT 6
`define PWR_DOWN_BIT 0
`define STAT_DONE_BIT 0
`define STAT_ABORT_BIT 1
`define CHAN_LAST_PIN 5'h18
`define CHAN_INT_REF 5'h19
`define NUM_PINS 25

// ***********************************************
// Reset values
// ***********************************************
`define RST_SCAN_CONTROL 7'h00
`define RST_POWERDOWN 1'h1
`define RST_SAMPLE_TIME 8'h00
`define RST_CLOCK_DIV 2'h0
`define RST_RESULT 12'h000
`define RST_PIN_SELECT 25'h0000000
`define RST_IRQ 2'h0

// ***********************************************
// Timing: divides of the 48 MHz source and sample unit
// ***********************************************
`define PLL_SOURCE_HZ 48000000
`define CONV_HZ_0 3000000
`define CONV_HZ_1 2000000
`define CONV_HZ_2 1500000
`define CONV_HZ_3 1000000
`define SAMPLE_UNIT 4
`define RESULT_BITS 12
`define SAR_MSB_MASK 12'h800

`endif

/* rtl/sar_adc_conversion_control.v */
/*
 * Conversion control of a single-ended 12-bit SAR converter with an APB
 * register slave, pin select outputs and one interrupt output.
 * Assumes an analog SAR array outside that takes dac_code and channel, and
 * returns comparator_high synchronous to pclk; all inputs synchronous to pclk.
 */
// What this block does
// R1: One start converts one selected channel, then stores result and raises interrupt.
// R2: Successive approximation produces one 12-bit code per conversion.
// R3: Converter clock divides the 48 MHz source to 3, 2, 1.5 or 1 MHz.
// R4: Power bit 0 of power register stops converter when 1; resets to 1.
// R5: Scan bit 6 chooses PWM timer trigger (1) or software start (0).
// R6: Scan bits 5..1 pick channel 0..24, or 25 for internal reference.
// R7: Start bit rising begins scan; completion clears start and sets flag.
// R8: Software clears the completion flag; hardware never clears it itself.
// R9: Writing start to 0 mid-scan aborts immediately and resets internal state.
// R10: Software sets start, waits interrupt, clears start; no changes mid-scan.
// R11: Result bits 7..0 in low register, 11..8 in high bits 3..0; reset 0.
// R12: Sampling lasts (N+1)*4 converter clock periods, N the 8-bit setting.
// R13: Completion event can wake the processor from wait mode.
// R14: Per-pin select bits enable converter function independent of scan channel.
// R15: Pin select bit n maps to channel n; 1 enables that pin.
// R16: A selected pin is forced to input, overriding its GPIO direction.
// R17: Both result registers update together at completion and hold otherwise.
// R18: While powered down, software and hardware starts are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defines.vh"

module sar_adc_conversion_control (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    input wire pwm_timer_trigger_out,
    input wire comparator_high,
    output reg conv_clk_out,
    output reg sample_hold,
    output reg [11:0] dac_code,
    output reg [4:0] channel_sel,
    output reg converter_busy,
    output wire converter_powerdown,
    input wire [24:0] gpio_oe_in,
    output wire [24:0] pin_analog_en,
    output wire [24:0] pad_oe,
    output wire wake_request,
    output wire irq
);

    // ***********************************************
    // States and divide constants
    // ***********************************************
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_SAMPLE = 2'd1;
    localparam [1:0] ST_CONVERT = 2'd2;
    localparam integer DIV_0_I = `PLL_SOURCE_HZ / `CONV_HZ_0;
    localparam integer DIV_1_I = `PLL_SOURCE_HZ / `CONV_HZ_1;
    localparam integer DIV_2_I = `PLL_SOURCE_HZ / `CONV_HZ_2;
    localparam integer DIV_3_I = `PLL_SOURCE_HZ / `CONV_HZ_3;
    localparam integer SAMPLE_UNIT_I = `SAMPLE_UNIT;
    localparam [5:0] DIV_0 = DIV_0_I[5:0];
    localparam [5:0] DIV_1 = DIV_1_I[5:0];
    localparam [5:0] DIV_2 = DIV_2_I[5:0];
    localparam [5:0] DIV_3 = DIV_3_I[5:0];
    localparam [10:0] SAMPLE_UNIT_W = SAMPLE_UNIT_I[10:0];

    // ***********************************************
    // Register state
    // ***********************************************
    reg start_q;
    reg [4:0] chan_q;
    reg trig_sel_q;
    reg powerdown_q;
    reg [7:0] sample_len_q;
    reg [1:0] clk_div_q;
    reg [11:0] result_q;
    reg [24:0] pin_sel_q;
    reg [1:0] irq_stat_q;
    reg [1:0] irq_mask_q;
    reg [1:0] state_q;
    reg [5:0] div_cnt_q;
    reg [10:0] sample_cnt_q;
    reg [11:0] bit_mask_q;
    reg [11:0] trial_q;

    wire [13:0] idx;
    wire aligned;
    wire setup_phase;
    wire wr_en;
    wire wr_scan;
    wire wr_power;
    wire wr_sample;
    wire wr_clkdiv;
    wire wr_pinsel;
    wire wr_status;
    wire wr_mask;
    wire hit;
    wire [5:0] div_sel;
    wire conv_tick;
    wire sw_start;
    wire hw_start;
    wire start_req;
    wire abort_req;
    wire done_evt;
    wire [11:0] decided;
    reg [31:0] rd_mux;

    // ***********************************************
    // APB decode
    // ***********************************************
    assign idx = paddr[15:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup_phase = psel & ~penable;
    assign hit = aligned & ((idx == `IDX_SCAN_CONTROL) | (idx == `IDX_RESULT_LOW) |
        (idx == `IDX_RESULT_HIGH) | (idx == `IDX_POWER_CONTROL) | (idx == `IDX_SAMPLE_TIME) |
        (idx == `IDX_CLOCK_CONTROL) | (idx == `IDX_PIN_SELECT) | (idx == `IDX_IRQ_STATUS) |
        (idx == `IDX_IRQ_MASK));
    // No wait states; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign wr_en = psel & penable & pwrite & hit;

    // ***********************************************
    // Write strobes, one per writable register
    // ***********************************************
    assign wr_scan = wr_en & (idx == `IDX_SCAN_CONTROL);
    assign wr_power = wr_en & (idx == `IDX_POWER_CONTROL);
    assign wr_sample = wr_en & (idx == `IDX_SAMPLE_TIME);
    assign wr_clkdiv = wr_en & (idx == `IDX_CLOCK_CONTROL);
    assign wr_pinsel = wr_en & (idx == `IDX_PIN_SELECT);
    assign wr_status = wr_en & (idx == `IDX_IRQ_STATUS);
    assign wr_mask = wr_en & (idx == `IDX_IRQ_MASK);

    always @* begin
        rd_mux = 32'h00000000;
        if (aligned) begin
            case (idx)
                `IDX_SCAN_CONTROL: rd_mux[6:0] = {trig_sel_q, chan_q, start_q};
                `IDX_RESULT_LOW: rd_mux[7:0] = result_q[7:0]; // R11
                `IDX_RESULT_HIGH: rd_mux[3:0] = result_q[11:8]; // R11
                `IDX_POWER_CONTROL: rd_mux[`PWR_DOWN_BIT] = powerdown_q;
                `IDX_SAMPLE_TIME: rd_mux[7:0] = sample_len_q;
                `IDX_CLOCK_CONTROL: rd_mux[1:0] = clk_div_q;
                `IDX_PIN_SELECT: rd_mux[24:0] = pin_sel_q;
                `IDX_IRQ_STATUS: rd_mux[1:0] = irq_stat_q;
                `IDX_IRQ_MASK: rd_mux[1:0] = irq_mask_q;
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase & ~pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ***********************************************
    // Converter clock divider
    // ***********************************************
    // Tick rate keeps the documented ratio to the 48 MHz source, counted in pclk
    assign div_sel = (clk_div_q == 2'h0) ? DIV_0 :
        (clk_div_q == 2'h1) ? DIV_1 :
        (clk_div_q == 2'h2) ? DIV_2 : DIV_3; // R3
    assign conv_tick = (div_cnt_q == div_sel - 6'd1) & ~powerdown_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 6'd0;
            conv_clk_out <= 1'b0;
        end else if (powerdown_q | (state_q == ST_IDLE)) begin
            div_cnt_q <= 6'd0;
            conv_clk_out <= 1'b0;
        end else if (conv_tick) begin
            div_cnt_q <= 6'd0;
            conv_clk_out <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_q + 6'd1;
            conv_clk_out <= (div_cnt_q >= {1'b0, div_sel[5:1]}) ? 1'b1 : 1'b0;
        end
    end

    // ***********************************************
    // Start, abort and completion
    // ***********************************************
    assign sw_start = wr_scan & ~trig_sel_q & ~start_q &
        pwdata[`SCAN_START_BIT] & (state_q == ST_IDLE); // R7
    assign hw_start = trig_sel_q & pwm_timer_trigger_out & (state_q == ST_IDLE); // R5
    assign start_req = (sw_start | hw_start) & ~powerdown_q; // R18
    // Powering down mid-scan also stops it, so no stale scan resumes later
    assign abort_req = (state_q != ST_IDLE) & ((wr_scan &
        ~pwdata[`SCAN_START_BIT]) | powerdown_q); // R9
    assign decided = comparator_high ? trial_q : (trial_q & ~bit_mask_q); // R2
    assign done_evt = (state_q == ST_CONVERT) & conv_tick & bit_mask_q[0] & ~abort_req; // R1

    // ***********************************************
    // Registers written by software
    // ***********************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {trig_sel_q, chan_q, start_q} <= `RST_SCAN_CONTROL;
            powerdown_q <= `RST_POWERDOWN; // R4
            sample_len_q <= `RST_SAMPLE_TIME;
            clk_div_q <= `RST_CLOCK_DIV;
            pin_sel_q <= `RST_PIN_SELECT;
            irq_mask_q <= `RST_IRQ;
        end else begin
            if (wr_scan) begin
                trig_sel_q <= pwdata[`SCAN_TRIG_BIT];
                chan_q <= pwdata[`SCAN_CHAN_MSB:`SCAN_CHAN_LSB]; // R6
                start_q <= pwdata[`SCAN_START_BIT] & ~powerdown_q; // R18
            end
            if (hw_start & ~powerdown_q) begin
                start_q <= 1'b1;
            end
            if (done_evt) begin
                start_q <= 1'b0; // R7
            end
            // Any abort drops start, so the next scan needs a clean 0 to 1
            if (abort_req) begin
                start_q <= 1'b0; // R9
            end
            if (wr_power) begin
                powerdown_q <= pwdata[`PWR_DOWN_BIT]; // R4
            end
            if (wr_sample) begin
                sample_len_q <= pwdata[7:0];
            end
            if (wr_clkdiv) begin
                clk_div_q <= pwdata[1:0];
            end
            if (wr_pinsel) begin
                pin_sel_q <= pwdata[24:0]; // R14
            end
            if (wr_mask) begin
                irq_mask_q <= pwdata[1:0];
            end
        end
    end

    // ***********************************************
    // Interrupt status, sticky, write one to clear
    // ***********************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= `RST_IRQ;
        end else begin
            // Set wins over a clear in the same cycle; only software clears
            irq_stat_q[`STAT_DONE_BIT] <= done_evt | (irq_stat_q[`STAT_DONE_BIT] &
                ~(wr_status & pwdata[`STAT_DONE_BIT])); // R8
            irq_stat_q[`STAT_ABORT_BIT] <= abort_req | (irq_stat_q[`STAT_ABORT_BIT] &
                ~(wr_status & pwdata[`STAT_ABORT_BIT]));
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q); // R1
    // Wake is unmasked so wait mode can end even with the line masked
    assign wake_request = irq_stat_q[`STAT_DONE_BIT]; // R13

    // ***********************************************
    // Sample and successive approximation sequencer
    // ***********************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            sample_cnt_q <= 11'h000;
            bit_mask_q <= 12'h000;
            trial_q <= 12'h000;
            result_q <= `RST_RESULT;
            sample_hold <= 1'b0;
            dac_code <= 12'h000;
            channel_sel <= 5'h00;
            converter_busy <= 1'b0;
        end else if (abort_req) begin
            state_q <= ST_IDLE; // R9
            sample_cnt_q <= 11'h000;
            bit_mask_q <= 12'h000;
            trial_q <= 12'h000;
            sample_hold <= 1'b0;
            dac_code <= 12'h000;
            converter_busy <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_req) begin
                        state_q <= ST_SAMPLE;
                        channel_sel <= sw_start ? pwdata[`SCAN_CHAN_MSB:`SCAN_CHAN_LSB] : chan_q; // R6
                        // Eleven bits, as 256 * 4 ticks overflow ten
                        sample_cnt_q <= ({3'h0, sample_len_q} + 11'h001) * SAMPLE_UNIT_W; // R12
                        sample_hold <= 1'b1;
                        converter_busy <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (conv_tick) begin
                        if (sample_cnt_q == 11'h001) begin
                            state_q <= ST_CONVERT; // R12
                            sample_hold <= 1'b0;
                            bit_mask_q <= `SAR_MSB_MASK;
                            trial_q <= `SAR_MSB_MASK;
                            dac_code <= `SAR_MSB_MASK;
                        end
                        sample_cnt_q <= sample_cnt_q - 11'h001;
                    end
                end
                ST_CONVERT: begin
                    if (conv_tick) begin
                        if (bit_mask_q[0]) begin
                            result_q <= decided; // R17
                            state_q <= ST_IDLE;
                            converter_busy <= 1'b0;
                            dac_code <= 12'h000;
                        end else begin
                            trial_q <= decided | (bit_mask_q >> 1); // R2
                            dac_code <= decided | (bit_mask_q >> 1);
                        end
                        bit_mask_q <= bit_mask_q >> 1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ***********************************************
    // Pin control
    // ***********************************************
    assign converter_powerdown = powerdown_q; // R4
    assign pin_analog_en = pin_sel_q; // R15
    // A selected pin never drives, whatever its GPIO direction says
    assign pad_oe = gpio_oe_in & ~pin_sel_q; // R16

endmodule
`default_nettype wire

/* tb/adc_ctrl_sva.sv */
/*
 * Port checker for the conversion control block.
 * Assumes binding into the design's top module, one pclk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pwm_timer_trigger_out,
    input wire logic conv_clk_out,
    input wire logic sample_hold,
    input wire logic [11:0] dac_code,
    input wire logic [4:0] channel_sel,
    input wire logic converter_busy,
    input wire logic converter_powerdown,
    input wire logic [24:0] gpio_oe_in,
    input wire logic [24:0] pin_analog_en,
    input wire logic [24:0] pad_oe,
    input wire logic wake_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_pd_blocks; converter_powerdown && !converter_busy |=> !converter_busy; endproperty
    a_pd_blocks: assert property (p_pd_blocks) else $error("scan began while powered down");
    property p_start_samples; $rose(converter_busy) |-> sample_hold; endproperty
    a_start_samples: assert property (p_start_samples) else $error("scan did not open with sampling");
    property p_pad_input; pad_oe == (gpio_oe_in & ~pin_analog_en); endproperty
    a_pad_input: assert property (p_pad_input) else $error("selected pin still driven");
    property p_wake_at_done; $rose(wake_request) |-> $fell(converter_busy); endproperty
    a_wake_at_done: assert property (p_wake_at_done) else $error("wake without completion");
    property p_msb_trial; $fell(sample_hold) && converter_busy |-> dac_code == 12'h800; endproperty
    a_msb_trial: assert property (p_msb_trial) else $error("first trial code wrong");
    property p_clk_idle; !converter_busy && !$past(converter_busy) |-> !conv_clk_out; endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("converter clock runs while idle");
    property p_chan_held; converter_busy && $past(converter_busy) |-> $stable(channel_sel); endproperty
    a_chan_held: assert property (p_chan_held) else $error("channel changed mid scan");
    property p_start_cause;
        $rose(converter_busy) |-> ($past(psel) && $past(penable) && $past(pwrite)) || $past(pwm_timer_trigger_out);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("scan began without a start");
endmodule
bind sar_adc_conversion_control adc_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwm_timer_trigger_out(pwm_timer_trigger_out),
    .conv_clk_out(conv_clk_out), .sample_hold(sample_hold), .dac_code(dac_code), .channel_sel(channel_sel),
    .converter_busy(converter_busy), .converter_powerdown(converter_powerdown), .gpio_oe_in(gpio_oe_in),
    .pin_analog_en(pin_analog_en), .pad_oe(pad_oe), .wake_request(wake_request));
`default_nettype wire

/* tb/sar_analog_model.sv */
/*
 * Behavioural analog SAR array: tracks vin while sampling, then compares.
 * Assumes vin is the level of the channel under conversion.
 */
`timescale 1ns/1ps
`default_nettype none
module sar_analog_model (
    input wire logic pclk,
    input wire logic sample_hold,
    input wire logic [11:0] dac_code,
    input wire logic [11:0] vin,
    output logic comparator_high
);
    logic [11:0] held_q = '0;
    // Registered compare: one pclk lag, far shorter than a tick
    always @(posedge pclk) begin
        if (sample_hold) begin
            held_q <= vin;
        end
        comparator_high <= (held_q >= dac_code);
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
/*
 * Register-level bench of the conversion control block over APB.
 * Assumes the defines header and the analog model beside the design.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defines.vh"
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trig = 0, serr;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0, rd;
    logic [11:0] vin = '0;
    logic [24:0] gpio_oe = '0;
    logic [4:0] ch_seen;
    wire pready, pslverr, conv_clk, sh, cmp, busy, pdown, wake, irq;
    wire [31:0] prdata;
    wire [11:0] dac;
    wire [4:0] chan;
    wire [24:0] pin_en, pad_oe;
    int error_cnt = 0, tests_run = 0, n, cnt;
    localparam logic [15:0] A_SCAN = {`IDX_SCAN_CONTROL, 2'b00}, A_LOW = {`IDX_RESULT_LOW, 2'b00};
    localparam logic [15:0] A_HIGH = {`IDX_RESULT_HIGH, 2'b00}, A_PWR = {`IDX_POWER_CONTROL, 2'b00};
    localparam logic [15:0] A_SPT = {`IDX_SAMPLE_TIME, 2'b00}, A_CLK = {`IDX_CLOCK_CONTROL, 2'b00};
    localparam logic [15:0] A_PIN = {`IDX_PIN_SELECT, 2'b00}, A_STAT = {`IDX_IRQ_STATUS, 2'b00};
    localparam logic [15:0] A_MASK = {`IDX_IRQ_MASK, 2'b00};
    int dtab [4] = '{`PLL_SOURCE_HZ / `CONV_HZ_0, `PLL_SOURCE_HZ / `CONV_HZ_1,
                     `PLL_SOURCE_HZ / `CONV_HZ_2, `PLL_SOURCE_HZ / `CONV_HZ_3};
    logic [4:0] ctab [4] = '{5'h00, 5'h08, `CHAN_LAST_PIN, `CHAN_INT_REF};
    logic [11:0] vtab [4] = '{12'h000, 12'h5A3, 12'hA5C, 12'hFFF};
    sar_adc_conversion_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .pwm_timer_trigger_out(trig), .comparator_high(cmp), .conv_clk_out(conv_clk), .sample_hold(sh),
        .dac_code(dac), .channel_sel(chan), .converter_busy(busy), .converter_powerdown(pdown),
        .gpio_oe_in(gpio_oe), .pin_analog_en(pin_en), .pad_oe(pad_oe), .wake_request(wake), .irq(irq));
    sar_analog_model u_ana (.pclk(pclk), .sample_hold(sh), .dac_code(dac), .vin(vin), .comparator_high(cmp));
    always #50 pclk = ~pclk;
    // ***********************************************
    // Shared tasks
    // ***********************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task fail;
        error_cnt++;
        end_sim;
    endtask
    // Zero-wait slave today, but the wait loop keeps the master honest
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        for (n = 0; pready !== 1'b1; n++) begin
            if (n == 20) fail;
            @(posedge pclk);
        end
        rd = prdata;
        serr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rdchk(input logic [15:0] a, input logic [31:0] e);
        apb(0, a, 0);
        check(rd, e);
    endtask
    // Counts sampling cycles until the completion interrupt
    task convert(input logic [31:0] scan, input logic [11:0] v);
        vin <= v;
        apb(1, A_SCAN, scan);
        cnt = 0;
        for (n = 0; irq !== 1'b1; n++) begin
            if (n == 9000) fail;
            // Sampled mid-cycle, where the outputs have settled
            @(negedge pclk);
            if (sh === 1'b1) cnt++;
            if (n == 3) ch_seen = chan;
        end
    endtask
    // ***********************************************
    // Tests
    // ***********************************************
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rdchk(A_PWR, 1);
        check(pdown, 1);
        rdchk(A_HIGH, 0);
        apb(1, A_LOW, 32'hFF);
        rdchk(A_LOW, 0);
        apb(0, 16'h0010, 0);
        check(serr, 1);
        check(rd, 0);
        gpio_oe <= '1;
        apb(1, A_PIN, 32'h0100_0005);
        #1;
        check(pin_en, 25'h100_0005);
        check(pad_oe, 25'h0FF_FFFA);
        $display("test reset and pins done");
        apb(1, A_MASK, 1);
        apb(1, A_SCAN, 1);
        repeat (40) @(posedge pclk);
        check(busy, 0);
        apb(1, A_SCAN, 0);
        apb(1, A_PWR, 0);
        #1;
        check(pdown, 0);
        $display("test powerdown done");
        for (int k = 0; k < 4; k++) begin
            apb(1, A_CLK, k);
            apb(1, A_SPT, k);
            convert({26'h0, ctab[k], 1'b1}, vtab[k]);
            check(cnt, (k + 1) * `SAMPLE_UNIT * dtab[k]);
            check(ch_seen, ctab[k]);
            check(wake, 1);
            rdchk(A_LOW, vtab[k][7:0]);
            rdchk(A_HIGH, vtab[k][11:8]);
            rdchk(A_SCAN, {ctab[k], 1'b0});
            apb(1, A_SCAN, 0);
            apb(1, A_STAT, 1);
            #1;
            check(irq, 0);
            check(wake, 0);
        end
        $display("test conversions done");
        apb(1, A_SPT, 32'hFF);
        apb(1, A_SCAN, 32'h3);
        repeat (30) @(posedge pclk);
        apb(1, A_SCAN, 0);
        rdchk(A_STAT, 2);
        check(busy, 0);
        rdchk(A_LOW, 32'hFF);
        apb(1, A_STAT, 3);
        apb(1, A_MASK, 3);
        apb(1, A_SCAN, 32'h3);
        repeat (10) @(posedge pclk);
        check(busy, 1);
        apb(1, A_PWR, 1);
        repeat (2) @(posedge pclk);
        check(busy, 0);
        check(irq, 1);
        rdchk(A_STAT, 2);
        rdchk(A_SCAN, 2);
        rdchk(A_LOW, 32'hFF);
        apb(1, A_PWR, 0);
        apb(1, A_STAT, 3);
        apb(1, A_MASK, 1);
        $display("test abort done");
        apb(1, A_SPT, 0);
        apb(1, A_CLK, 0);
        apb(1, A_SCAN, 32'h70);
        vin <= 12'h3C7;
        repeat (20) @(posedge pclk);
        check(busy, 0);
        trig <= 1;
        @(posedge pclk);
        trig <= 0;
        for (n = 0; irq !== 1'b1; n++) begin
            if (n == 9000) fail;
            @(negedge pclk);
        end
        rdchk(A_LOW, 32'hC7);
        rdchk(A_HIGH, 32'h3);
        rdchk(A_SCAN, 32'h70);
        $display("test hardware trigger done");
        end_sim;
    end
endmodule
`default_nettype wire
